// ===== pkg/fpo_pkg.sv
// Purpose: Shared constants and types for the FPU operand handling block
// Assumes: Register indices are five bits; operands are at most 64 bits
// Notes: Default non-number patterns depend on the encoding select input
`default_nettype none
package fpo_pkg;
	localparam int unsigned REG_COUNT = 32;
	localparam int unsigned IDX_W = 5;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned DATA_W = 64;
	// Field layout of the two floating formats
	localparam int unsigned SGL_EXP_LSB = 23;
	localparam int unsigned SGL_EXP_W = 8;
	localparam int unsigned SGL_SIGN = 31;
	localparam int unsigned DBL_EXP_LSB = 52;
	localparam int unsigned DBL_EXP_W = 11;
	localparam int unsigned DBL_SIGN = 63;
	// Freshly created quiet non-numbers
	localparam logic [31:0] SGL_QNAN_LEGACY = 32'h7FBF_FFFF;
	localparam logic [31:0] SGL_QNAN_2008 = 32'h7FFF_FFFF;
	localparam logic [63:0] DBL_QNAN_LEGACY = 64'h7FF7_FFFF_FFFF_FFFF;
	localparam logic [63:0] DBL_QNAN_2008 = 64'h7FFF_FFFF_FFFF_FFFF;
	// Largest positive integers, supplied on invalid conversions
	localparam logic [31:0] WORD_MAX = 32'h7FFF_FFFF;
	localparam logic [63:0] LONG_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
	localparam logic [31:0] SGL_INF = 32'h7F80_0000;
	localparam logic [63:0] DBL_INF = 64'h7FF0_0000_0000_0000;
	typedef enum logic [4:0] {
		OP_LDW, OP_LDD, OP_MTW, OP_MTH, OP_STW, OP_STD, OP_MFW, OP_MFH,
		OP_MOV, OP_MOVC, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CLT, OP_CEQ,
		OP_CVTW, OP_CVTL
	} fpo_op_t;
	typedef enum logic [1:0] {FMT_S, FMT_D, FMT_W, FMT_L} fpo_fmt_t;
	typedef enum logic [2:0] {TAG_UNINT, TAG_S, TAG_D, TAG_W, TAG_L, TAG_UNK} fpo_tag_t;
	typedef struct packed {
		logic sign;
		logic nan;
		logic inf;
		logic zero;
		logic fmsb;
	} fpo_cls_t;
endpackage : fpo_pkg
`default_nettype wire

// ===== hdl/fpo_operand_unit.sv
// Purpose: Register file with format tracking and special-value handling
// Assumes: One request per cycle; answer registered one cycle later
// Notes: Finite arithmetic is left to the host datapath via needs_arith
`default_nettype none
// Overview of operation
// - Division by zero default result is a correctly signed infinity.
// - Compare orders minus infinity below finites, finites below plus infinity.
// - Infinity arithmetic with a real limit is exact, silent, and propagates.
// - Infinity operations without a meaningful limit raise invalid operation.
// - Signalling non-number operands raise invalid outside moves; arithmetic never produces a signalling result.
// - Formatted moves, conditional ones too, never signal any exception.
// - Quiet non-number operands cause no exception in arithmetic; compares and conversions raise invalid.
// - Quiet non-number input gives quiet result, copying an operand when possible.
// - Comparisons treat quiet non-numbers like signalling ones.
// - New quiet non-number pattern chosen by format and encoding select.
// - Non-number or infinity converted to integer gives largest positive integer, trap disabled.
// - New quiet non-number only for invalid without quiet inputs, trap disabled.
// - Signed two's complement word and long integer formats only.
// - Width select high gives thirty-two 64-bit registers for any format.
// - Width select low gives 32-bit registers, doubles in even-odd pairs.
// - Paired mode: double operation naming an odd source, or an odd destination that this unit writes, is reserved.
// - Paired mode: high half move naming an odd register is reserved.
// - Single and word data in low 32 bits; double and long use all.
// - Loads and moves from core tag uninterpreted; results carry produced format.
// - Uninterpreted source read in a format takes that format permanently.
// - Source of mismatched format makes register and result unknown.
// - Stores and moves out keep the tag and output raw bits.
// - Fraction top bit tells quiet from signalling, inverted by encoding select.
module fpo_operand_unit #(
	parameter int unsigned REG_COUNT = fpo_pkg::REG_COUNT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Mode controls
	input wire logic register_width_select,
	input wire logic nan_encoding_select,
	input wire logic invalid_trap_enable,
	// Request
	input wire logic req_valid,
	input wire fpo_pkg::fpo_op_t req_op,
	input wire fpo_pkg::fpo_fmt_t req_fmt,
	input wire logic [fpo_pkg::IDX_W-1:0] req_fs,
	input wire logic [fpo_pkg::IDX_W-1:0] req_ft,
	input wire logic [fpo_pkg::IDX_W-1:0] req_fd,
	input wire logic [fpo_pkg::DATA_W-1:0] req_data,
	input wire logic req_cond,
	// Response
	output logic rsp_valid,
	output logic [fpo_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_cond,
	output logic rsp_invalid,
	output logic rsp_div_zero,
	output logic rsp_reserved,
	output logic rsp_trap,
	output logic rsp_needs_arith,
	output logic rsp_unknown
);
	if (REG_COUNT != (1 << fpo_pkg::IDX_W))
	begin : g_chk
		$error("REG_COUNT must match the register index width");
	end

	logic [fpo_pkg::DATA_W-1:0] mem_q [REG_COUNT];
	fpo_pkg::fpo_tag_t tag_q [REG_COUNT];

	function automatic logic [fpo_pkg::IDX_W-1:0] odd(input logic [fpo_pkg::IDX_W-1:0] i);
		return {i[fpo_pkg::IDX_W-1:1], 1'b1};
	endfunction

	// Operand view of a register, pairing in narrow mode
	function automatic logic [63:0] rd(input logic [fpo_pkg::IDX_W-1:0] i, input logic dbl,
		input logic wide);
		if (dbl && !wide)
			return {mem_q[odd(i)][31:0], mem_q[i][31:0]};
		else if (dbl)
			return mem_q[i];
		return {32'h0000_0000, mem_q[i][31:0]};
	endfunction

	function automatic fpo_pkg::fpo_cls_t classify(input logic [63:0] v, input logic dbl);
		fpo_pkg::fpo_cls_t c;
		logic eall;
		logic ezero;
		logic fzero;
		if (dbl)
		begin
			eall = &v[fpo_pkg::DBL_EXP_LSB +: fpo_pkg::DBL_EXP_W];
			ezero = ~|v[fpo_pkg::DBL_EXP_LSB +: fpo_pkg::DBL_EXP_W];
			fzero = ~|v[fpo_pkg::DBL_EXP_LSB-1:0];
			c.sign = v[fpo_pkg::DBL_SIGN];
			c.fmsb = v[fpo_pkg::DBL_EXP_LSB-1];
		end
		else
		begin
			eall = &v[fpo_pkg::SGL_EXP_LSB +: fpo_pkg::SGL_EXP_W];
			ezero = ~|v[fpo_pkg::SGL_EXP_LSB +: fpo_pkg::SGL_EXP_W];
			fzero = ~|v[fpo_pkg::SGL_EXP_LSB-1:0];
			c.sign = v[fpo_pkg::SGL_SIGN];
			c.fmsb = v[fpo_pkg::SGL_EXP_LSB-1];
		end
		c.nan = eall & ~fzero;
		c.inf = eall & fzero;
		c.zero = ezero & fzero;
		return c;
	endfunction

	function automatic logic [63:0] signed_inf(input logic s, input logic dbl);
		if (dbl)
			return {s, fpo_pkg::DBL_INF[62:0]};
		return {32'h0000_0000, s, fpo_pkg::SGL_INF[30:0]};
	endfunction

	// Sign-magnitude order; plus and minus zero compare equal
	function automatic logic less(input logic [63:0] a, input logic [63:0] b,
		input fpo_pkg::fpo_cls_t ca, input fpo_pkg::fpo_cls_t cb, input logic dbl);
		logic [62:0] ma;
		logic [62:0] mb;
		ma = dbl ? a[62:0] : {32'h0000_0000, a[30:0]};
		mb = dbl ? b[62:0] : {32'h0000_0000, b[30:0]};
		if (ca.zero && cb.zero)
			return 1'b0;
		if (ca.sign != cb.sign)
			return ca.sign;
		return ca.sign ? (ma > mb) : (ma < mb);
	endfunction

	function automatic fpo_pkg::fpo_tag_t fmt_tag(input fpo_pkg::fpo_fmt_t f);
		unique case (f)
			fpo_pkg::FMT_S: return fpo_pkg::TAG_S;
			fpo_pkg::FMT_D: return fpo_pkg::TAG_D;
			fpo_pkg::FMT_W: return fpo_pkg::TAG_W;
			fpo_pkg::FMT_L: return fpo_pkg::TAG_L;
		endcase
	endfunction

	// Tag after a formatted read of a register
	function automatic fpo_pkg::fpo_tag_t tag_use(input fpo_pkg::fpo_tag_t t,
		input fpo_pkg::fpo_tag_t f);
		return (t == fpo_pkg::TAG_UNINT || t == f) ? f : fpo_pkg::TAG_UNK;
	endfunction

	logic wide;
	logic src_dbl, dst_dbl, use_a, use_b, fmt_bad, odd_bad, rsv, inv, dz, arith, cond;
	logic wr_lo, wr_hi, sn_a, sn_b, qn_a, qn_b, xs, bs, unk;
	logic [63:0] op_a, op_b, qnew, qcopy, res, out;
	fpo_pkg::fpo_cls_t ca, cb;
	fpo_pkg::fpo_tag_t ntag_a, ntag_b, wtag;

	assign wide = register_width_select;

	always_comb
	begin
		src_dbl = (req_fmt == fpo_pkg::FMT_D) || (req_fmt == fpo_pkg::FMT_L);
		dst_dbl = src_dbl;
		use_a = 1'b0;
		use_b = 1'b0;
		fmt_bad = 1'b0;
		odd_bad = 1'b0;
		inv = 1'b0;
		dz = 1'b0;
		arith = 1'b0;
		cond = 1'b0;
		wr_lo = 1'b0;
		wr_hi = 1'b0;
		op_a = rd(req_fs, src_dbl, wide);
		op_b = rd(req_ft, src_dbl, wide);
		ca = classify(op_a, src_dbl);
		cb = classify(op_b, src_dbl);
		sn_a = ca.nan & (ca.fmsb ^ nan_encoding_select);
		sn_b = cb.nan & (cb.fmsb ^ nan_encoding_select);
		qn_a = ca.nan & ~sn_a;
		qn_b = cb.nan & ~sn_b;
		if (src_dbl)
			qnew = nan_encoding_select ? fpo_pkg::DBL_QNAN_2008 : fpo_pkg::DBL_QNAN_LEGACY;
		else
			qnew = {32'h0000_0000, nan_encoding_select ? fpo_pkg::SGL_QNAN_2008 :
				fpo_pkg::SGL_QNAN_LEGACY};
		qcopy = qn_a ? op_a : op_b;
		xs = ca.sign ^ cb.sign;
		bs = cb.sign ^ (req_op == fpo_pkg::OP_SUB);
		res = op_a;
		out = 64'h0000_0000_0000_0000;
		ntag_a = tag_use(tag_q[req_fs], fmt_tag(req_fmt));
		ntag_b = tag_use(tag_q[req_ft], fmt_tag(req_fmt));
		wtag = fmt_tag(req_fmt);
		unique case (req_op)
			fpo_pkg::OP_LDW, fpo_pkg::OP_MTW:
			begin
				wr_lo = 1'b1;
				res = req_data;
				wtag = fpo_pkg::TAG_UNINT;
				src_dbl = 1'b0;
				dst_dbl = 1'b0;
			end
			fpo_pkg::OP_LDD:
			begin
				{wr_lo, wr_hi} = 2'b11;
				res = req_data;
				wtag = fpo_pkg::TAG_UNINT;
				src_dbl = 1'b0;
				dst_dbl = 1'b1;
			end
			fpo_pkg::OP_MTH:
			begin
				wr_hi = 1'b1;
				res = {req_data[31:0], 32'h0000_0000};
				wtag = fpo_pkg::TAG_UNINT;
				src_dbl = 1'b0;
				dst_dbl = 1'b1;
			end
			fpo_pkg::OP_STW, fpo_pkg::OP_MFW, fpo_pkg::OP_STD, fpo_pkg::OP_MFH:
			begin
				src_dbl = (req_op == fpo_pkg::OP_STD) || (req_op == fpo_pkg::OP_MFH);
				dst_dbl = 1'b0;
				if (req_op == fpo_pkg::OP_STD)
					out = rd(req_fs, 1'b1, wide);
				else if (req_op == fpo_pkg::OP_MFH)
					out = {32'h0000_0000, wide ? mem_q[req_fs][63:32] : mem_q[odd(req_fs)][31:0]};
				else
					out = {32'h0000_0000, mem_q[req_fs][31:0]};
			end
			fpo_pkg::OP_MOV, fpo_pkg::OP_MOVC:
			begin
				use_a = 1'b1;
				wr_lo = (req_op == fpo_pkg::OP_MOV) || req_cond;
				wr_hi = wr_lo & src_dbl;
			end
			fpo_pkg::OP_ADD, fpo_pkg::OP_SUB, fpo_pkg::OP_MUL, fpo_pkg::OP_DIV:
			begin
				use_a = 1'b1;
				use_b = 1'b1;
				fmt_bad = (req_fmt == fpo_pkg::FMT_W) || (req_fmt == fpo_pkg::FMT_L);
				if (sn_a || sn_b)
				begin
					inv = 1'b1;
					res = (qn_a || qn_b) ? qcopy : qnew;
				end
				else if (qn_a || qn_b)
					res = qcopy;
				else if (req_op == fpo_pkg::OP_ADD || req_op == fpo_pkg::OP_SUB)
				begin
					if (ca.inf && cb.inf && (ca.sign != bs))
						inv = 1'b1;
					else if (ca.inf)
						res = signed_inf(ca.sign, src_dbl);
					else if (cb.inf)
						res = signed_inf(bs, src_dbl);
					else
						arith = 1'b1;
				end
				else if (req_op == fpo_pkg::OP_MUL)
				begin
					if ((ca.inf && cb.zero) || (cb.inf && ca.zero))
						inv = 1'b1;
					else if (ca.inf || cb.inf)
						res = signed_inf(xs, src_dbl);
					else
						arith = 1'b1;
				end
				else
				begin
					if ((ca.inf && cb.inf) || (ca.zero && cb.zero))
						inv = 1'b1;
					else if (ca.inf)
						res = signed_inf(xs, src_dbl);
					else if (cb.inf)
						res = src_dbl ? {xs, 63'h0} : {32'h0000_0000, xs, 31'h0};
					else if (cb.zero)
					begin
						dz = 1'b1;
						res = signed_inf(xs, src_dbl);
					end
					else
						arith = 1'b1;
				end
				if (inv && !(qn_a || qn_b))
					res = qnew;
				wr_lo = ~arith;
				wr_hi = ~arith & src_dbl;
			end
			fpo_pkg::OP_CLT, fpo_pkg::OP_CEQ:
			begin
				use_a = 1'b1;
				use_b = 1'b1;
				fmt_bad = (req_fmt == fpo_pkg::FMT_W) || (req_fmt == fpo_pkg::FMT_L);
				if (ca.nan || cb.nan)
					inv = 1'b1;
				else if (req_op == fpo_pkg::OP_CLT)
					cond = less(op_a, op_b, ca, cb, src_dbl);
				else
					cond = (ca.zero && cb.zero) || (op_a == op_b);
			end
			fpo_pkg::OP_CVTW, fpo_pkg::OP_CVTL:
			begin
				use_a = 1'b1;
				fmt_bad = (req_fmt == fpo_pkg::FMT_W) || (req_fmt == fpo_pkg::FMT_L);
				dst_dbl = (req_op == fpo_pkg::OP_CVTL);
				wtag = dst_dbl ? fpo_pkg::TAG_L : fpo_pkg::TAG_W;
				if (ca.nan || ca.inf)
				begin
					inv = 1'b1;
					res = dst_dbl ? fpo_pkg::LONG_MAX : {32'h0000_0000, fpo_pkg::WORD_MAX};
				end
				else
					arith = 1'b1;
				wr_lo = ~arith;
				wr_hi = ~arith & dst_dbl;
			end
			// Undefined op codes act as reserved, so nothing is written
			default:
				fmt_bad = 1'b1;
		endcase
		// Mismatched source format poisons register and result
		unk = (use_a && ntag_a == fpo_pkg::TAG_UNK) || (use_b && ntag_b == fpo_pkg::TAG_UNK) ||
			(!use_a && tag_q[req_fs] == fpo_pkg::TAG_UNK && (out != 64'h0));
		if (unk && use_a)
			wtag = fpo_pkg::TAG_UNK;
		if (!use_a && !wr_lo && !wr_hi)
			unk = (tag_q[req_fs] == fpo_pkg::TAG_UNK);
		odd_bad = !wide && ((src_dbl && (req_fs[0] || (use_b && req_ft[0]))) ||
			(dst_dbl && (wr_lo || wr_hi) && req_fd[0]));
		rsv = fmt_bad || odd_bad;
		if (rsv || (inv && invalid_trap_enable) || !req_valid)
		begin
			wr_lo = 1'b0;
			wr_hi = 1'b0;
		end
		if (rsv || !req_valid)
		begin
			use_a = 1'b0;
			use_b = 1'b0;
			inv = 1'b0;
			dz = 1'b0;
		end
		if (wr_lo || wr_hi)
			out = res;
	end

	// Data words carry no reset; tags do
	always_ff @(posedge clock)
	begin
		if (wr_lo)
			mem_q[req_fd][31:0] <= res[31:0];
		if (wr_hi && wide)
			mem_q[req_fd][63:32] <= res[63:32];
		else if (wr_hi)
			mem_q[odd(req_fd)][31:0] <= res[63:32];
	end

	// Destination tag written last so it wins over a source retag
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < REG_COUNT; i++)
				tag_q[i] <= fpo_pkg::TAG_UNINT;
		end
		else
		begin
			if (use_a)
				tag_q[req_fs] <= ntag_a;
			if (use_a && src_dbl && !wide)
				tag_q[odd(req_fs)] <= ntag_a;
			if (use_b)
				tag_q[req_ft] <= ntag_b;
			if (use_b && src_dbl && !wide)
				tag_q[odd(req_ft)] <= ntag_b;
			if (wr_lo || wr_hi)
				tag_q[req_fd] <= wtag;
			if ((wr_lo || wr_hi) && dst_dbl && !wide)
				tag_q[odd(req_fd)] <= wtag;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rsp_valid <= 1'b0;
			rsp_data <= 64'h0000_0000_0000_0000;
			rsp_cond <= 1'b0;
			rsp_invalid <= 1'b0;
			rsp_div_zero <= 1'b0;
			rsp_reserved <= 1'b0;
			rsp_trap <= 1'b0;
			rsp_needs_arith <= 1'b0;
			rsp_unknown <= 1'b0;
		end
		else
		begin
			rsp_valid <= req_valid;
			rsp_data <= req_valid ? out : 64'h0000_0000_0000_0000;
			rsp_cond <= req_valid & ~rsv & cond;
			rsp_invalid <= inv;
			rsp_div_zero <= dz;
			rsp_reserved <= req_valid & rsv;
			rsp_trap <= inv & invalid_trap_enable;
			rsp_needs_arith <= req_valid & ~rsv & arith;
			rsp_unknown <= req_valid & ~rsv & unk;
		end
	end
endmodule // fpo_operand_unit
`default_nettype wire

// ===== testbench/fpo_operand_monitor.sv
// Purpose: Port checks for the operand unit
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound from the bench top file
`default_nettype none
module fpo_operand_monitor #(
	parameter int unsigned REG_COUNT = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Modes
	input wire logic register_width_select,
	input wire logic nan_encoding_select,
	input wire logic invalid_trap_enable,
	// Request
	input wire logic req_valid,
	input wire fpo_pkg::fpo_op_t req_op,
	input wire fpo_pkg::fpo_fmt_t req_fmt,
	input wire logic [fpo_pkg::IDX_W-1:0] req_fs,
	input wire logic [fpo_pkg::IDX_W-1:0] req_fd,
	// Response
	input wire logic rsp_valid,
	input wire logic [fpo_pkg::DATA_W-1:0] rsp_data,
	input wire logic rsp_cond,
	input wire logic rsp_invalid,
	input wire logic rsp_reserved,
	input wire logic rsp_trap,
	input wire logic rsp_needs_arith,
	input wire logic rsp_unknown
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	logic hi_move, out_move, pair_req;
	assign hi_move = req_op inside {fpo_pkg::OP_MTH, fpo_pkg::OP_MFH};
	assign out_move = req_op inside {fpo_pkg::OP_STW, fpo_pkg::OP_STD, fpo_pkg::OP_MFW};
	assign pair_req = req_valid && !register_width_select;
	chk_answer_next: assert property (req_valid |=> rsp_valid)
		else $error("response missing after request");
	chk_paired_odd_dbl: assert property (
		pair_req && req_op == fpo_pkg::OP_ADD && req_fmt == fpo_pkg::FMT_D && req_fs[0]
		|=> rsp_reserved) else $error("odd double register accepted");
	chk_paired_odd_half: assert property (
		pair_req && hi_move && req_fs[0] && req_fd[0] |=> rsp_reserved)
		else $error("odd high half move accepted");
	chk_wide_half_legal: assert property (
		req_valid && register_width_select && hi_move |=> !rsp_reserved)
		else $error("high half move refused in wide mode");
	chk_move_silent: assert property (
		req_valid && req_op inside {fpo_pkg::OP_MOV, fpo_pkg::OP_MOVC}
		|=> !rsp_invalid && !rsp_trap) else $error("formatted move raised a flag");
	chk_store_plain: assert property (
		req_valid && out_move |=> !rsp_invalid && !rsp_needs_arith && !rsp_trap)
		else $error("outward transfer raised a flag");
	chk_cvt_word_max: assert property (
		rsp_valid && rsp_invalid && !rsp_trap && $past(req_op) == fpo_pkg::OP_CVTW
		|-> rsp_data[31:0] == fpo_pkg::WORD_MAX) else $error("bad invalid conversion value");
	chk_cmp_unordered: assert property (
		rsp_valid && rsp_invalid && $past(req_op) inside {fpo_pkg::OP_CLT, fpo_pkg::OP_CEQ}
		|-> !rsp_cond) else $error("unordered compare reported true");
	chk_trap_enabled: assert property (rsp_trap |-> $past(invalid_trap_enable))
		else $error("trap without enable");
	chk_no_snan_out: assert property (
		rsp_valid && $past(req_op) == fpo_pkg::OP_ADD && $past(req_fmt) == fpo_pkg::FMT_S
		&& !rsp_reserved && !rsp_unknown && !rsp_needs_arith && !rsp_trap
		&& rsp_data[30:23] == 8'hFF && rsp_data[21:0] != 22'h0
		|-> rsp_data[22] == $past(nan_encoding_select)) else $error("signalling result made");
	cover property (rsp_valid && rsp_reserved);
	cover property (rsp_valid && rsp_trap);
	cover property (rsp_valid && rsp_invalid && !rsp_trap);
endmodule // fpo_operand_monitor
`default_nettype wire

// ===== testbench/fpo_host_model.sv
// Purpose: Host core model issuing coprocessor requests
// Assumes: Requests change 1 ns after a rising edge
// Notes: Fields scramble once the strobe drops
`default_nettype none
module fpo_host_model (
	// Clock
	input wire logic clock,
	// Request
	output logic req_valid,
	output fpo_pkg::fpo_op_t req_op,
	output fpo_pkg::fpo_fmt_t req_fmt,
	output logic [4:0] req_fs,
	output logic [4:0] req_ft,
	output logic [4:0] req_fd,
	output logic [63:0] req_data,
	output logic req_cond
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		req_valid = 1'b0;
		req_op = fpo_pkg::OP_LDW;
		req_fmt = fpo_pkg::FMT_S;
		{req_fs, req_ft, req_fd, req_data, req_cond} = '0;
	end
	// Held until the next call, so requests can run back to back
	task automatic issue(input fpo_pkg::fpo_op_t op, input fpo_pkg::fpo_fmt_t fmt,
		input logic [4:0] fs, ft, fd, input logic [63:0] d, input logic c);
		@(posedge clock);
		#1;
		{req_valid, req_op, req_fmt} = {1'b1, op, fmt};
		{req_fs, req_ft, req_fd, req_data, req_cond} = {fs, ft, fd, d, c};
	endtask
	task automatic idle();
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		{req_fs, req_fd, req_data} = ~{req_fs, req_fd, req_data};
	endtask
endmodule // fpo_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the operand unit
// Assumes: Host model issues one request per cycle
// Notes: Expectations queue at issue and retire on each response
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [63:0] d;
		logic [63:0] dm;
		logic [6:0] f;
		logic [6:0] fm;
	} fpo_exp_t;
	localparam logic [6:0] INV = 7'h40, DZ = 7'h20, RES = 7'h10, TRP = 7'h08, UNK = 7'h02;
	logic clock, rst, wide, nan_sel, trap_en, req_valid, req_cond, rsp_valid, rsp_cond;
	logic rsp_invalid, rsp_div_zero, rsp_reserved, rsp_trap, rsp_needs_arith, rsp_unknown;
	fpo_pkg::fpo_op_t req_op;
	fpo_pkg::fpo_fmt_t req_fmt;
	logic [4:0] req_fs, req_ft, req_fd;
	logic [63:0] req_data, rsp_data, r64;
	logic [31:0] r;
	logic [6:0] flags;
	logic [15:0] lfsr_q = 16'h2048;
	fpo_exp_t e;
	fpo_exp_t want_q[$];
	int fail_count = 0;
	int samples_checked = 0;
	assign flags = {rsp_invalid, rsp_div_zero, rsp_reserved, rsp_trap, rsp_needs_arith,
		rsp_unknown, rsp_cond};
	fpo_host_model host (.clock, .req_valid, .req_op, .req_fmt, .req_fs, .req_ft, .req_fd,
		.req_data, .req_cond);
	fpo_operand_unit #(.REG_COUNT(32)) uut (.clock, .rst, .register_width_select(wide),
		.nan_encoding_select(nan_sel), .invalid_trap_enable(trap_en), .req_valid, .req_op,
		.req_fmt, .req_fs, .req_ft, .req_fd, .req_data, .req_cond, .rsp_valid, .rsp_data,
		.rsp_cond, .rsp_invalid, .rsp_div_zero, .rsp_reserved, .rsp_trap, .rsp_needs_arith,
		.rsp_unknown);
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	function automatic logic [31:0] rnd32();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return {lfsr_q, ~lfsr_q};
	endfunction
	task automatic check(input logic [70:0] seen, input logic [70:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	// Condition input rides on data bit 0 to keep calls short
	task automatic run(input fpo_pkg::fpo_op_t op, input fpo_pkg::fpo_fmt_t fmt,
		input int fs, ft, fd, input logic [63:0] din, d, input logic [6:0] f,
		input logic [6:0] fm = 7'h7F, input bit care = 1'b1);
		logic [63:0] dm;
		dm = !care ? 64'h0 : fmt == fpo_pkg::FMT_S ? 64'h0000_0000_FFFF_FFFF : '1;
		want_q.push_back('{d & dm, dm, f & fm, fm});
		host.issue(op, fmt, fs[4:0], ft[4:0], fd[4:0], din, din[0]);
	endtask
	task automatic mode(input logic w, n, t);
		host.idle();
		{wide, nan_sel, trap_en} = {w, n, t};
	endtask
	always @(negedge clock)
		if (rsp_valid === 1'b1)
		begin
			if (want_q.size() == 0)
				check(71'h1, 71'h0);
			else
			begin
				e = want_q.pop_front();
				check({rsp_data & e.dm, flags & e.fm}, {e.d, e.f});
			end
		end
	task automatic final_report();
		if (want_q.size() != 0)
			fail_count++;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		final_report();
	end
	initial
	begin
		{rst, wide, nan_sel, trap_en} = 4'hC;
		repeat (6) @(posedge clock);
		#1;
		rst = 1'b0;
		r = rnd32();
		run(fpo_pkg::OP_LDW, fpo_pkg::FMT_D, 0, 0, 1, {~r, r}, {~r, r}, 7'h00);
		run(fpo_pkg::OP_MFW, fpo_pkg::FMT_D, 1, 0, 0, 64'h0, {32'h0, r}, 7'h00);
		run(fpo_pkg::OP_MTH, fpo_pkg::FMT_S, 1, 0, 1, {~r, r}, 64'h0, 7'h00, 7'h7F, 0);
		run(fpo_pkg::OP_MFH, fpo_pkg::FMT_D, 1, 0, 0, 64'h0, {32'h0, r}, 7'h00);
		run(fpo_pkg::OP_LDD, fpo_pkg::FMT_D, 0, 0, 2, fpo_pkg::DBL_INF, fpo_pkg::DBL_INF, 7'h00);
		run(fpo_pkg::OP_LDD, fpo_pkg::FMT_D, 0, 0, 3, 64'h3FF0_0000_0000_0000,
			64'h3FF0_0000_0000_0000, 7'h00);
		run(fpo_pkg::OP_LDD, fpo_pkg::FMT_D, 0, 0, 4, 64'h0, 64'h0, 7'h00);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_D, 2, 3, 5, 64'h0, fpo_pkg::DBL_INF, 7'h00);
		run(fpo_pkg::OP_DIV, fpo_pkg::FMT_D, 3, 4, 6, 64'h0, fpo_pkg::DBL_INF, DZ);
		run(fpo_pkg::OP_SUB, fpo_pkg::FMT_D, 2, 2, 7, 64'h0, fpo_pkg::DBL_QNAN_LEGACY, INV);
		run(fpo_pkg::OP_CLT, fpo_pkg::FMT_D, 3, 2, 0, 64'h0, 64'h0, 7'h01, 7'h7F, 0);
		run(fpo_pkg::OP_LDW, fpo_pkg::FMT_S, 0, 0, 8, 64'h7FFF_FFFF, 64'h7FFF_FFFF, 7'h00);
		run(fpo_pkg::OP_LDW, fpo_pkg::FMT_S, 0, 0, 9, 64'h7FBF_FFFF, 64'h7FBF_FFFF, 7'h00);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_S, 8, 8, 10, 64'h0, 64'h7FBF_FFFF, INV);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_S, 9, 9, 11, 64'h0, 64'h7FBF_FFFF, 7'h00);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_S, 8, 9, 11, 64'h0, 64'h7FBF_FFFF, INV);
		run(fpo_pkg::OP_CEQ, fpo_pkg::FMT_S, 9, 9, 0, 64'h0, 64'h0, INV, 7'h7F, 0);
		run(fpo_pkg::OP_MOV, fpo_pkg::FMT_S, 8, 0, 12, 64'h0, 64'h7FFF_FFFF, 7'h00);
		run(fpo_pkg::OP_MOVC, fpo_pkg::FMT_S, 8, 0, 13, 64'h0, 64'h0, 7'h00, 7'h7F, 0);
		run(fpo_pkg::OP_CVTW, fpo_pkg::FMT_S, 8, 0, 14, 64'h0, 64'h7FFF_FFFF, INV);
		run(fpo_pkg::OP_CVTL, fpo_pkg::FMT_D, 2, 0, 15, 64'h0, fpo_pkg::LONG_MAX, INV);
		run(fpo_pkg::OP_STW, fpo_pkg::FMT_D, 8, 0, 0, 64'h0, 64'h7FFF_FFFF, 7'h00);
		run(fpo_pkg::OP_MUL, fpo_pkg::FMT_D, 2, 4, 17, 64'h0, fpo_pkg::DBL_QNAN_LEGACY, INV);
		// Finite operands are left to the host datapath
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_D, 3, 3, 18, 64'h0, 64'h0, 7'h04);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_W, 3, 3, 18, 64'h0, 64'h0, RES, 7'h7F, 0);
		run(fpo_pkg::OP_MTW, fpo_pkg::FMT_S, 0, 0, 19, {~r, r}, {32'h0, r}, 7'h00);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_D, 8, 8, 16, 64'h0, 64'h0, UNK, UNK, 0);
		mode(1'b1, 1'b1, 1'b0);
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_S, 9, 9, 11, 64'h0, 64'h7FFF_FFFF, INV);
		run(fpo_pkg::OP_SUB, fpo_pkg::FMT_D, 2, 2, 7, 64'h0, fpo_pkg::DBL_QNAN_2008, INV);
		mode(1'b1, 1'b0, 1'b1);
		run(fpo_pkg::OP_SUB, fpo_pkg::FMT_D, 2, 2, 7, 64'h0, 64'h0, TRP, TRP, 0);
		mode(1'b0, 1'b0, 1'b0);
		r64 = {rnd32(), rnd32()};
		run(fpo_pkg::OP_ADD, fpo_pkg::FMT_D, 3, 4, 1, 64'h0, 64'h0, RES, 7'h7F, 0);
		run(fpo_pkg::OP_MTH, fpo_pkg::FMT_S, 5, 0, 5, r64, 64'h0, RES, 7'h7F, 0);
		run(fpo_pkg::OP_LDD, fpo_pkg::FMT_D, 0, 0, 20, r64, r64, 7'h00);
		run(fpo_pkg::OP_STD, fpo_pkg::FMT_D, 20, 0, 0, 64'h0, r64, 7'h00);
		run(fpo_pkg::OP_MFW, fpo_pkg::FMT_D, 21, 0, 0, 64'h0, {32'h0, r64[63:32]}, 7'h00);
		run(fpo_pkg::OP_MFH, fpo_pkg::FMT_D, 20, 0, 20, 64'h0, {32'h0, r64[63:32]}, 7'h00);
		host.idle();
		repeat (3) @(posedge clock);
		final_report();
	end
endmodule // tb_top
bind fpo_operand_unit fpo_operand_monitor #(.REG_COUNT(REG_COUNT)) mon (.clock, .rst,
	.register_width_select, .nan_encoding_select, .invalid_trap_enable, .req_valid, .req_op,
	.req_fmt, .req_fs, .req_fd, .rsp_valid, .rsp_data, .rsp_cond, .rsp_invalid, .rsp_reserved,
	.rsp_trap, .rsp_needs_arith, .rsp_unknown);
`default_nettype wire
